// ==== pkg/imsc_cfg.svh ====
// Purpose: offsets, field positions and reset values of the interrupt mask block
// Assumes: byte addresses on a plain register port
// Notes: included by the design file and the bench
`ifndef IMSC_CFG_SVH
`define IMSC_CFG_SVH
`define IMSC_ADDR_W 8
`define IMSC_OFS_SET 8'h88
`define IMSC_OFS_CLR 8'h8C
`define IMSC_BIT_GLOBAL 31
`define IMSC_BIT_MAKER 30
`define IMSC_BIT_SOFT 29
`define IMSC_RSVD_MASK 32'h10007C00
`define IMSC_IMPL_MASK 32'hEFFF83FF
`define IMSC_RESET_VAL 32'h00000000
`define IMSC_EVT_MASK 32'h6FFF83FF
`endif

// ==== pkg/imsc_pkg.sv ====
// Purpose: shared types of the interrupt mask block
// Assumes: 32-bit register words
// Notes: constants live in imsc_cfg.svh
package imsc_pkg;
    typedef logic [31:0] imsc_word_t;
    typedef logic [7:0] imsc_addr_t;
endpackage

// ==== rtl/imsc_irq_mask.sv ====
// Purpose: interrupt mask register with set and clear views and global enable
// Assumes: event register lives outside and arrives as a level vector
// Notes: read data valid only in the cycle after the read strobe
`timescale 1ns/1ps
`include "imsc_cfg.svh"

// What this block does
// RQ1: read of either view returns mask
// RQ2: set view at 88h, clear at 8Ch
// RQ3: mask bits align with event bits
// RQ4: global enable bit 31 allows interrupt
// RQ5: global enable zero blocks interrupt always
// RQ6: bit 30 with event 30 allows interrupt
// RQ7: bit 29 with event 29 allows interrupt
// RQ8: bit 28 reserved, reads zero
// RQ9: bit 27 with event 27 allows interrupt
// RQ10: bit 26 with event 26 allows interrupt
// RQ11: bit 25 with event 25 allows interrupt
// RQ12: bit 24 with event 24 allows interrupt
// RQ13: bits 23 to 20 gate cycle events
// RQ14: bits 19 and 18 gate their events
// RQ15: bits 17 to 15 gate reset events
// RQ16: bits 14 to 10 reserved, read zero
// RQ17: bits 9 and 8 gate error events
// RQ18: bits 7 and 6 gate iso DMA
// RQ19: bits 5 and 4 gate packet arrival
// RQ20: bits 3 and 2 gate receive DMA
// RQ21: bits 1 and 0 gate sent events
// RQ22: bits 15 to 12 read zero after reset
// RQ23: ones set or clear, zeros keep
// RQ24: irq when enabled and event AND mask nonzero
module imsc_irq_mask #(
    parameter int DATA_W = 32,
    parameter int ADDR_W = `IMSC_ADDR_W
)
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire imsc_pkg::imsc_addr_t addr_i,
    input wire imsc_pkg::imsc_word_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire imsc_pkg::imsc_word_t event_i,
    output imsc_pkg::imsc_word_t rdata_o,
    output logic irq_o,
    output imsc_pkg::imsc_word_t mask_o
);
    import imsc_pkg::*;

    // bit maps fixed by the register layout
    localparam imsc_word_t IMPL_BITS = `IMSC_IMPL_MASK;
    localparam imsc_word_t RSVD_BITS = `IMSC_RSVD_MASK;
    localparam imsc_word_t EVT_BITS = `IMSC_EVT_MASK;
    localparam imsc_addr_t SET_OFS = `IMSC_OFS_SET;
    localparam imsc_addr_t CLR_OFS = `IMSC_OFS_CLR;

    imsc_word_t mask_q;
    wire imsc_word_t mask_d;
    wire imsc_word_t allow_bits;
    imsc_word_t rdata_q;
    logic irq_q;
    logic irq_d;
    logic hit_set;
    logic hit_clr;
    logic set_stb;
    logic clr_stb;
    logic rd_hit;

    // the bit maps and the ports are sized for one register word only
    if (DATA_W != $bits(imsc_word_t))
    begin : g_chk_data_w
        $error("DATA_W must equal the register word width");
    end
    if (ADDR_W != $bits(imsc_addr_t))
    begin : g_chk_addr_w
        $error("ADDR_W must equal the address port width");
    end
    if ((IMPL_BITS & RSVD_BITS) != 32'h00000000)
    begin : g_chk_maps
        $error("a reserved bit is marked implemented");
    end

    // undefined printed defaults are resolved to zero so no interrupt fires from reset
    assign hit_set = (addr_i == SET_OFS); // RQ2
    assign hit_clr = (addr_i == CLR_OFS); // RQ2
    // one address per access, so set and clear can never meet in one cycle
    assign set_stb = wr_i && hit_set;
    assign clr_stb = wr_i && hit_clr;
    assign rd_hit = rd_i && (hit_set || hit_clr);

    for (genvar b = 0; b < DATA_W; b++)
    begin : g_bit
        if (IMPL_BITS[b])
        begin : g_store
            assign mask_d[b] = set_stb ? (mask_q[b] | wdata_i[b]) : // RQ23
                clr_stb ? (mask_q[b] & ~wdata_i[b]) :
                mask_q[b];
        end
        else
        begin : g_rsvd
            // reserved bits never store, so they read zero
            assign mask_d[b] = 1'b0; // RQ8 RQ16 RQ22
        end
        if (EVT_BITS[b])
        begin : g_gate
            // same position on both sides: events are never remapped
            assign allow_bits[b] = event_i[b] & mask_d[b]; // RQ3 RQ6 RQ7 RQ9 RQ10 RQ11 RQ12
            // RQ13 RQ14 RQ15 RQ17 RQ18 RQ19 RQ20 RQ21

            property p_bit_gate;
                @(posedge sys_clk_i) disable iff (reset_i)
                (mask_d[`IMSC_BIT_GLOBAL] && mask_d[b] && event_i[b]) |=> irq_o;
            endproperty
            a_bit_gate: assert property (p_bit_gate) else $error("event gave no irq"); // RQ4
        end
        else
        begin : g_no_gate
            // the global enable and the reserved bits are not event gates
            assign allow_bits[b] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            mask_q <= `IMSC_RESET_VAL; // RQ22
        end
        else
        begin
            mask_q <= mask_d;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rdata_q <= 32'h00000000;
        end
        else if (rd_hit)
        begin
            rdata_q <= mask_q; // RQ1
        end
        else
        begin
            // unmapped reads and idle cycles return zero
            rdata_q <= 32'h00000000;
        end
    end

    // one bit per position: events 30..29, 27..15 and 9..0 gated by the same-numbered mask bit
    always_comb
    begin
        // the next mask is used so an enable write takes effect at once
        irq_d = mask_d[`IMSC_BIT_GLOBAL] && (|allow_bits); // RQ4 RQ5 RQ24
    end

    // registered output: one cycle behind the event, changing on the same edge as the mask
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_d;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o = irq_q;
    assign mask_o = mask_q;

    property p_rd_mask;
        @(posedge sys_clk_i) disable iff (reset_i)
        (rd_i && (hit_set || hit_clr) && !wr_i) |=> (rdata_o == $past(mask_q));
    endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("read did not return mask"); // RQ1

    property p_rd_unmapped;
        @(posedge sys_clk_i) disable iff (reset_i)
        (rd_i && !hit_set && !hit_clr) |=> (rdata_o == 32'h00000000);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero"); // RQ2

    property p_set;
        @(posedge sys_clk_i) disable iff (reset_i)
        (wr_i && hit_set) |=> ((mask_o & $past(wdata_i) & `IMSC_IMPL_MASK)
            == ($past(wdata_i) & `IMSC_IMPL_MASK));
    endproperty
    a_set: assert property (p_set) else $error("set write missed a bit"); // RQ23

    property p_clr;
        @(posedge sys_clk_i) disable iff (reset_i)
        (wr_i && hit_clr) |=> ((mask_o & $past(wdata_i)) == 32'h00000000);
    endproperty
    a_clr: assert property (p_clr) else $error("clear write missed a bit"); // RQ23

    property p_keep;
        @(posedge sys_clk_i) disable iff (reset_i)
        (wr_i && hit_set) |=> ((mask_o & ~$past(wdata_i)) == ($past(mask_q) & ~$past(wdata_i)));
    endproperty
    a_keep: assert property (p_keep) else $error("zero bits changed on set"); // RQ23

    property p_rsvd;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mask_o & `IMSC_RSVD_MASK) == 32'h00000000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved mask bit set"); // RQ8

    property p_rsvd_rd;
        @(posedge sys_clk_i) disable iff (reset_i)
        rd_i |=> (rdata_o[14:10] == 5'h00);
    endproperty
    a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved field read nonzero"); // RQ16

    property p_global_off;
        @(posedge sys_clk_i) disable iff (reset_i)
        !mask_o[`IMSC_BIT_GLOBAL] |-> !irq_o;
    endproperty
    a_global_off: assert property (p_global_off) else $error("irq with global off"); // RQ5

    property p_irq_on;
        @(posedge sys_clk_i) disable iff (reset_i)
        irq_o == (mask_o[`IMSC_BIT_GLOBAL] && (|(($past(event_i)) & mask_o & `IMSC_EVT_MASK)));
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq disagrees with mask and event"); // RQ24

    property p_soft;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mask_d[`IMSC_BIT_GLOBAL] && mask_d[`IMSC_BIT_SOFT] && event_i[`IMSC_BIT_SOFT]) |=> irq_o;
    endproperty
    a_soft: assert property (p_soft) else $error("software irq not raised"); // RQ7

    property p_maker_gate;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mask_d[`IMSC_BIT_GLOBAL] && mask_d[30] && event_i[30]) |=> irq_o;
    endproperty
    a_maker_gate: assert property (p_maker_gate) else $error("maker irq not raised"); // RQ6

    property p_late_ack;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mask_d[`IMSC_BIT_GLOBAL] && mask_d[27] && event_i[27]) |=> irq_o;
    endproperty
    a_late_ack: assert property (p_late_ack) else $error("late ack irq not raised"); // RQ9

    property p_ll_reg;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mask_d[`IMSC_BIT_GLOBAL] && mask_d[26] && event_i[26]) |=> irq_o;
    endproperty
    a_ll_reg: assert property (p_ll_reg) else $error("register arrival irq not raised"); // RQ10

    property p_overlong;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mask_d[`IMSC_BIT_GLOBAL] && mask_d[25] && event_i[25]) |=> irq_o;
    endproperty
    a_overlong: assert property (p_overlong) else $error("overlong cycle irq not raised"); // RQ11

    property p_fatal;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mask_d[`IMSC_BIT_GLOBAL] && mask_d[24] && event_i[24]) |=> irq_o;
    endproperty
    a_fatal: assert property (p_fatal) else $error("fatal error irq not raised"); // RQ12

    property p_cycle_evt;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mask_d[`IMSC_BIT_GLOBAL] && (|(mask_d[23:20] & event_i[23:20]))) |=> irq_o;
    endproperty
    a_cycle_evt: assert property (p_cycle_evt) else $error("cycle irq not raised"); // RQ13

    property p_ll_status;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mask_d[`IMSC_BIT_GLOBAL] && (|(mask_d[19:18] & event_i[19:18]))) |=> irq_o;
    endproperty
    a_ll_status: assert property (p_ll_status) else $error("status irq not raised"); // RQ14

    property p_reinit;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mask_d[`IMSC_BIT_GLOBAL] && (|(mask_d[17:15] & event_i[17:15]))) |=> irq_o;
    endproperty
    a_reinit: assert property (p_reinit) else $error("reinit irq not raised"); // RQ15

    property p_err_evt;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mask_d[`IMSC_BIT_GLOBAL] && (|(mask_d[9:8] & event_i[9:8]))) |=> irq_o;
    endproperty
    a_err_evt: assert property (p_err_evt) else $error("error irq not raised"); // RQ17

    property p_iso_dma;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mask_d[`IMSC_BIT_GLOBAL] && (|(mask_d[7:6] & event_i[7:6]))) |=> irq_o;
    endproperty
    a_iso_dma: assert property (p_iso_dma) else $error("iso dma irq not raised"); // RQ18

    property p_pkt;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mask_d[`IMSC_BIT_GLOBAL] && (|(mask_d[5:4] & event_i[5:4]))) |=> irq_o;
    endproperty
    a_pkt: assert property (p_pkt) else $error("packet irq not raised"); // RQ19

    property p_rx_dma;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mask_d[`IMSC_BIT_GLOBAL] && (|(mask_d[3:2] & event_i[3:2]))) |=> irq_o;
    endproperty
    a_rx_dma: assert property (p_rx_dma) else $error("receive dma irq not raised"); // RQ20

    property p_sent;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mask_d[`IMSC_BIT_GLOBAL] && (|(mask_d[1:0] & event_i[1:0]))) |=> irq_o;
    endproperty
    a_sent: assert property (p_sent) else $error("sent irq not raised"); // RQ21

    property p_irq_quiet;
        @(posedge sys_clk_i) disable iff (reset_i)
        !(|(event_i & mask_d & `IMSC_EVT_MASK)) |=> !irq_o;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq without enabled event"); // RQ24

    property p_rdata_idle;
        @(posedge sys_clk_i) disable iff (reset_i)
        !rd_hit |=> (rdata_o == 32'h00000000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outlived its cycle"); // RQ1

    property p_unmapped_wr;
        @(posedge sys_clk_i) disable iff (reset_i)
        (wr_i && !hit_set && !hit_clr) |=> (mask_o == $past(mask_q));
    endproperty
    a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write moved mask"); // RQ2

    property p_clr_keep;
        @(posedge sys_clk_i) disable iff (reset_i)
        (wr_i && hit_clr) |=> (((mask_o ^ $past(mask_q)) & ~$past(wdata_i)) == 32'h00000000);
    endproperty
    a_clr_keep: assert property (p_clr_keep) else $error("zero bits changed on clear"); // RQ23

    property p_mask_hold;
        @(posedge sys_clk_i) disable iff (reset_i)
        !wr_i |=> (mask_o == $past(mask_q));
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask moved without a write"); // RQ23

    property p_rsvd28_rd;
        @(posedge sys_clk_i) disable iff (reset_i)
        rd_i |=> !rdata_o[28];
    endproperty
    a_rsvd28_rd: assert property (p_rsvd28_rd) else $error("bit 28 read nonzero"); // RQ8

    property p_global_set;
        @(posedge sys_clk_i) disable iff (reset_i)
        (wr_i && hit_set && wdata_i[`IMSC_BIT_GLOBAL]) |=> mask_o[`IMSC_BIT_GLOBAL];
    endproperty
    a_global_set: assert property (p_global_set) else $error("global enable not set"); // RQ4

    property p_global_clr;
        @(posedge sys_clk_i) disable iff (reset_i)
        (wr_i && hit_clr && wdata_i[`IMSC_BIT_GLOBAL]) |=> !mask_o[`IMSC_BIT_GLOBAL];
    endproperty
    a_global_clr: assert property (p_global_clr) else $error("global enable not cleared"); // RQ5

    property p_bit15_store;
        @(posedge sys_clk_i) disable iff (reset_i)
        (wr_i && hit_set && wdata_i[15]) |=> mask_o[15];
    endproperty
    a_bit15_store: assert property (p_bit15_store) else $error("bit 15 did not store"); // RQ15
endmodule

// ==== verification/imsc_tb.sv ====
// Purpose: self-checking bench for the interrupt mask block
// Assumes: event vector is a level driven by the bench
// Notes: reset read first, then row table, then boundary and reset cases by hand
`timescale 1ns/1ps
`include "imsc_cfg.svh"
module testbench;
    import imsc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    imsc_addr_t addr_i = 8'h00;
    imsc_word_t wdata_i = 32'h00000000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    imsc_word_t event_i = 32'h00000000;
    imsc_word_t rdata_o;
    logic irq_o;
    imsc_word_t mask_o;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    // set value, event, mask expected, irq expected
    imsc_word_t rows [11][4] = '{
        '{32'hA0000000, 32'h20000000, 32'hA0000000, 32'h00000001},
        '{32'h84000000, 32'h04000000, 32'h84000000, 32'h00000001},
        '{32'h80000001, 32'h00000001, 32'h80000001, 32'h00000001},
        '{32'h7FFFFFFF, 32'hFFFFFFFF, 32'h6FFF83FF, 32'h00000000},
        '{32'hC0000000, 32'h40000000, 32'hC0000000, 32'h00000001},
        '{32'hA0000000, 32'h40000000, 32'hA0000000, 32'h00000000},
        '{32'h88000000, 32'h08000000, 32'h88000000, 32'h00000001},
        '{32'h80008000, 32'h00008000, 32'h80008000, 32'h00000001},
        '{32'h80000400, 32'h00000400, 32'h80000000, 32'h00000000},
        '{32'h80000080, 32'h80000040, 32'h80000080, 32'h00000000},
        '{32'hFFFFFFFF, 32'h10007C00, 32'hEFFF83FF, 32'h00000000}};
    imsc_irq_mask dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .event_i(event_i),
        .rdata_o(rdata_o), .irq_o(irq_o), .mask_o(mask_o));
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    task report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // whole run needs about 130 cycles
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            report_and_stop;
        end
    end
    task cmp(input string nm, input imsc_word_t exp, input imsc_word_t got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // strobe stays up so calls may run back to back; idle drops it
    task bus(input logic w, input imsc_addr_t a, input imsc_word_t d);
        wr_i <= w;
        rd_i <= ~w;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
    endtask
    task idle;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    // read data stand only in the cycle after the strobe, so look mid-cycle
    task rd_chk(input imsc_addr_t a, input imsc_word_t exp);
        bus(1'b0, a, 32'h00000000);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(negedge sys_clk_i);
        cmp("rdata", exp, rdata_o);
        @(posedge sys_clk_i);
    endtask
    initial
    begin
        repeat (16) @(posedge sys_clk_i);
        cmp("mask", 32'h00000000, mask_o);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        rd_chk(`IMSC_OFS_SET, 32'h00000000);
        $display("test reset done");
        for (int i = 0; i < 11; i++)
        begin
            event_i <= rows[i][1];
            bus(1'b1, `IMSC_OFS_CLR, 32'hFFFFFFFF);
            bus(1'b1, `IMSC_OFS_SET, rows[i][0]);
            idle;
            @(negedge sys_clk_i);
            cmp("mask", rows[i][2], mask_o);
            cmp("irq", rows[i][3], {31'h0, irq_o});
            @(posedge sys_clk_i);
            rd_chk(`IMSC_OFS_SET, rows[i][2]);
            rd_chk(`IMSC_OFS_CLR, rows[i][2]);
            $display("test row %0d done", i);
        end
        event_i <= 32'h00000001;
        bus(1'b1, `IMSC_OFS_SET, 32'hFFFFFFFF);
        bus(1'b1, `IMSC_OFS_CLR, 32'h0000FFFE);
        rd_chk(`IMSC_OFS_CLR, 32'hEFFF0001);
        @(negedge sys_clk_i);
        cmp("rdata", 32'h00000000, rdata_o);
        cmp("irq", 32'h00000001, {31'h0, irq_o});
        @(posedge sys_clk_i);
        bus(1'b1, 8'h84, 32'hFFFFFFFF);
        bus(1'b1, `IMSC_OFS_CLR, 32'h00000000);
        idle;
        @(negedge sys_clk_i);
        cmp("mask", 32'hEFFF0001, mask_o);
        @(posedge sys_clk_i);
        rd_chk(8'h80, 32'h00000000);
        bus(1'b1, `IMSC_OFS_CLR, 32'h80000000);
        idle;
        @(negedge sys_clk_i);
        cmp("irq", 32'h00000000, {31'h0, irq_o});
        @(posedge sys_clk_i);
        reset_i <= 1'b1;
        @(negedge sys_clk_i);
        cmp("mask", 32'h00000000, mask_o);
        cmp("irq", 32'h00000000, {31'h0, irq_o});
        @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        bus(1'b1, `IMSC_OFS_SET, 32'h80000001);
        rd_chk(`IMSC_OFS_SET, 32'h80000001);
        @(negedge sys_clk_i);
        cmp("irq", 32'h00000001, {31'h0, irq_o});
        $display("test boundary done");
        report_and_stop;
    end
endmodule
